// File: design/nta_activation_fsm.sv
/*
 * network-side layer-one activation state machine with supervision,
 * reactivation guard and optional activation hold timers.
 * assumes receiver events and requests are synchronous one-cycle pulses.
 */
// Function
// - guard timer lasts 25 to 100 ms, programmable; GUARD_MS is not bounded, and zero is accepted.
// - zero guard allowed; deactivate then goes straight to deactivated.
// - supervision timer covers whole access activation time.
// - management deactivate and error indications may be suppressed.
// - optional 100 ms hold before operational frames and activate indications.
// - idle line declared after 48 or more consecutive ones.
// - framed activation sent within 1 s of wake.
// - operational frames sent within 500 ms of synced frames.
// - idle or lost framing brings framed activation within 25 ms, no deactivation.
`timescale 1ns/100ps
`include "nta_defines.svh"
module nta_activation_fsm #(
    parameter int SUPERVISION_MS = `NTA_SUPERVISION_MS,
    parameter int GUARD_MS = `NTA_GUARD_MS,
    parameter int HOLD_MS = `NTA_HOLD_MS,
    parameter int MS_CYCLES = `NTA_MS_CYCLES,
    parameter int IDLE_ONES = `NTA_IDLE_ONES,
    parameter bit HOLD_ENABLE = 1'b0,
    parameter bit FORWARD_MGMT = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire nta_pkg::nta_rx_s rx,
    input wire logic activate_request,
    input wire logic deactivate_request,
    output nta_pkg::nta_tx_e tx_signal,
    output nta_pkg::nta_state_e state,
    output nta_pkg::nta_ind_s ind
);
    import nta_pkg::*;

    // ----------------------------------------
    // millisecond tick
    // ----------------------------------------
    logic [24:0] ms_div;
    logic [24:0] next_ms_div;
    logic ms_tick;
    logic next_ms_tick;

    // divider runs free so timers share one tick
    always_comb begin
        next_ms_tick = 1'b0;
        next_ms_div = ms_div + 25'h1;
        if (ms_div == 25'(MS_CYCLES - 1)) begin
            next_ms_div = '0;
            next_ms_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ms_div <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_div <= next_ms_div;
            ms_tick <= next_ms_tick;
        end
    end

    // ----------------------------------------
    // idle line detector
    // ----------------------------------------
    logic [6:0] ones;
    logic [6:0] next_ones;
    logic idle_rx;

    // counts consecutive ones, saturating at the threshold
    always_comb begin
        next_ones = ones;
        if (rx.rx_bit_valid) begin
            if (!rx.rx_bit) begin
                next_ones = '0;
            end else if (ones < 7'(IDLE_ONES)) begin
                next_ones = ones + 7'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ones <= '0;
        end else begin
            ones <= next_ones;
        end
    end

    assign idle_rx = (ones >= 7'(IDLE_ONES));

    // ----------------------------------------
    // timers
    // ----------------------------------------
    logic sup_start, sup_stop, sup_expired, sup_running;
    logic grd_start, grd_expired, grd_running;
    logic hold_start, hold_stop, hold_expired, hold_running;

    // supervision spans exchange and terminal sections
    nta_ms_timer #(.WIDTH(16)) u_supervision (
        .clk(clk), .resetn(resetn), .ms_tick(ms_tick),
        .start(sup_start), .stop(sup_stop),
        .load_ms(16'(SUPERVISION_MS)),
        .running(sup_running), .expired(sup_expired)
    );

    // guard against unintended reactivation
    nta_ms_timer #(.WIDTH(16)) u_guard (
        .clk(clk), .resetn(resetn), .ms_tick(ms_tick),
        .start(grd_start), .stop(1'b0),
        .load_ms(16'(GUARD_MS)),
        .running(grd_running), .expired(grd_expired)
    );

    // optional hold before going operational
    nta_ms_timer #(.WIDTH(16)) u_hold (
        .clk(clk), .resetn(resetn), .ms_tick(ms_tick),
        .start(hold_start), .stop(hold_stop),
        .load_ms(16'(HOLD_MS)),
        .running(hold_running), .expired(hold_expired)
    );

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    nta_state_e next_state;
    nta_tx_e next_tx;
    nta_ind_s next_ind;
    logic deact_now;

    // guard of zero moves deactivation straight to deactivated
    assign deact_now = deactivate_request || (sup_expired && state == NTA_STATE_PENDING_ACTIVATION);

    always_comb begin
        next_state = state;
        next_ind = '0;
        sup_start = 1'b0;
        sup_stop = 1'b0;
        grd_start = 1'b0;
        hold_start = 1'b0;
        hold_stop = 1'b0;
        case (state)
            NTA_STATE_DEACTIVATED: begin
                if (rx.terminal_wake_signal || activate_request) begin
                    sup_start = 1'b1;
                    next_state = NTA_STATE_PENDING_ACTIVATION;
                end
            end
            NTA_STATE_PENDING_ACTIVATION: begin
                if (deact_now) begin
                    sup_stop = 1'b1;
                    hold_stop = 1'b1;
                    next_ind.link_layer_deactivate_indication = 1'b1;
                    if (GUARD_MS == 0) begin
                        next_state = NTA_STATE_DEACTIVATED;
                    end else begin
                        grd_start = 1'b1;
                        next_state = NTA_STATE_PENDING_DEACTIVATION;
                    end
                end else if (rx.synchronized_terminal_frames && !(HOLD_ENABLE && hold_running)) begin
                    if (HOLD_ENABLE && !hold_expired) begin
                        hold_start = 1'b1;
                    end else begin
                        sup_stop = 1'b1;
                        next_ind.link_layer_activate_indication = 1'b1;
                        next_ind.mgmt_activate_indication = 1'b1;
                        next_state = NTA_STATE_ACTIVE;
                    end
                end else if (HOLD_ENABLE && hold_expired) begin
                    sup_stop = 1'b1;
                    next_ind.link_layer_activate_indication = 1'b1;
                    next_ind.mgmt_activate_indication = 1'b1;
                    next_state = NTA_STATE_ACTIVE;
                end
            end
            NTA_STATE_ACTIVE: begin
                if (deactivate_request) begin
                    next_ind.link_layer_deactivate_indication = 1'b1;
                    if (GUARD_MS == 0) begin
                        next_state = NTA_STATE_DEACTIVATED;
                    end else begin
                        grd_start = 1'b1;
                        next_state = NTA_STATE_PENDING_DEACTIVATION;
                    end
                end else if (rx.lost_framing || idle_rx) begin
                    next_ind.mgmt_deactivate_indication = FORWARD_MGMT;
                    next_ind.mgmt_error_indication = FORWARD_MGMT;
                    next_state = NTA_STATE_PENDING_ACTIVATION;
                end
            end
            NTA_STATE_PENDING_DEACTIVATION: begin
                if (activate_request) begin
                    sup_start = 1'b1;
                    next_state = NTA_STATE_PENDING_ACTIVATION;
                end else if (grd_expired || idle_rx) begin
                    next_state = NTA_STATE_DEACTIVATED;
                end
            end
            default: begin
                next_state = NTA_STATE_DEACTIVATED;
            end
        endcase
    end

    // transmitted signal follows the next state
    always_comb begin
        case (next_state)
            NTA_STATE_PENDING_ACTIVATION: next_tx = NTA_TX_FRAMED_ACTIVATION_SIGNAL;
            NTA_STATE_ACTIVE: next_tx = NTA_TX_OPERATIONAL_FRAMES;
            default: next_tx = NTA_TX_IDLE_LINE_SIGNAL;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= NTA_STATE_DEACTIVATED;
            tx_signal <= NTA_TX_IDLE_LINE_SIGNAL;
            ind <= '0;
        end else begin
            state <= next_state;
            tx_signal <= next_tx;
            ind <= next_ind;
        end
    end

endmodule

// File: design/nta_defines.svh
/*
 * timing constants for the line-side activation state machine.
 * assumes a 20 MHz clock; included by bare name.
 */
`ifndef NTA_DEFINES_SVH
`define NTA_DEFINES_SVH

// ----------------------------------------
// clock and base tick
// ----------------------------------------
`define NTA_CLK_HZ 20000000
`define NTA_MS_CYCLES (`NTA_CLK_HZ / 1000)

// ----------------------------------------
// timer values in their own units
// ----------------------------------------
`define NTA_GUARD_MS 25
`define NTA_GUARD_MIN_MS 25
`define NTA_GUARD_MAX_MS 100
`define NTA_SUPERVISION_MS 30000
`define NTA_HOLD_MS 100
`define NTA_IDLE_ONES 48
`define NTA_WAKE_LIMIT_MS 1000
`define NTA_OPER_LIMIT_MS 500
`define NTA_RESPONSE_MS 25

`endif

// File: design/nta_ms_timer.sv
/*
 * millisecond down-counter with start, stop and one-cycle expiry.
 * assumes a free-running millisecond tick from the parent.
 */
`timescale 1ns/100ps
module nta_ms_timer #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ms_tick,
    input wire logic start,
    input wire logic stop,
    input wire logic [WIDTH-1:0] load_ms,
    output logic running,
    output logic expired
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_running;
    logic next_expired;

    // countdown; a zero load expires two cycles after start
    always_comb begin
        next_count = count;
        next_running = running;
        next_expired = 1'b0;
        if (start) begin
            next_count = load_ms;
            next_running = 1'b1;
        end else if (stop) begin
            next_running = 1'b0;
        end else if (running) begin
            if (count == '0) begin
                next_running = 1'b0;
                next_expired = 1'b1;
            end else if (ms_tick) begin
                next_count = count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            running <= next_running;
            expired <= next_expired;
        end
    end

endmodule

// File: design/nta_pkg.sv
/*
 * types for the line-side activation state machine.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package nta_pkg;

    // states, gray coded along deact -> pend_act -> active -> pend_deact
    typedef enum logic [1:0] {
        NTA_STATE_DEACTIVATED = 2'b00,
        NTA_STATE_PENDING_ACTIVATION = 2'b01,
        NTA_STATE_ACTIVE = 2'b11,
        NTA_STATE_PENDING_DEACTIVATION = 2'b10
    } nta_state_e;

    // line signal chosen for transmission
    typedef enum logic [1:0] {
        NTA_TX_IDLE_LINE_SIGNAL = 2'b00,
        NTA_TX_FRAMED_ACTIVATION_SIGNAL = 2'b01,
        NTA_TX_OPERATIONAL_FRAMES = 2'b10
    } nta_tx_e;

    // line events from the receiver
    typedef struct packed {
        logic terminal_wake_signal;
        logic synchronized_terminal_frames;
        logic lost_framing;
        logic rx_bit_valid;
        logic rx_bit;
    } nta_rx_s;

    // indications, one-cycle pulses
    typedef struct packed {
        logic link_layer_activate_indication;
        logic link_layer_deactivate_indication;
        logic mgmt_activate_indication;
        logic mgmt_deactivate_indication;
        logic mgmt_error_indication;
    } nta_ind_s;

endpackage

// File: testbench/nta_activation_fsm_monitor.sv
/*
 * assertions for the line-side activation state machine.
 * assumes binding to nta_activation_fsm with matching timer parameters.
 */
`timescale 1ns/100ps
module nta_activation_fsm_monitor #(
    parameter int GUARD_MS = 2,
    parameter int MS_CYCLES = 4,
    parameter int IDLE_ONES = 48
) (
    input wire logic clk,
    input wire logic resetn,
    input wire nta_pkg::nta_rx_s rx,
    input wire logic activate_request,
    input wire logic deactivate_request,
    input wire nta_pkg::nta_tx_e tx_signal,
    input wire nta_pkg::nta_state_e state,
    input wire nta_pkg::nta_ind_s ind
);
    import nta_pkg::*;
    localparam int GUARD_LO = GUARD_MS * MS_CYCLES - 1;
    localparam int GUARD_HI = (GUARD_MS + 1) * MS_CYCLES + 2;
    logic [7:0] ones_cnt;
    // run of consecutive valid ones, saturating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ones_cnt <= 8'h00;
        end else if (rx.rx_bit_valid) begin
            ones_cnt <= !rx.rx_bit ? 8'h00 : (ones_cnt == 8'hff ? ones_cnt : ones_cnt + 8'h01);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_wake_to_pending: assert property (
        state == NTA_STATE_DEACTIVATED && rx.terminal_wake_signal |=> state == NTA_STATE_PENDING_ACTIVATION)
        else $error("wake did not start activation");
    a_sync_to_active: assert property (
        state == NTA_STATE_PENDING_ACTIVATION && rx.synchronized_terminal_frames && !deactivate_request
        |=> state == NTA_STATE_ACTIVE && ind.link_layer_activate_indication && ind.mgmt_activate_indication)
        else $error("synced frames did not activate");
    a_lost_to_pending: assert property (
        state == NTA_STATE_ACTIVE && rx.lost_framing && !deactivate_request |=> state == NTA_STATE_PENDING_ACTIVATION
        && ind.mgmt_deactivate_indication && ind.mgmt_error_indication && !ind.link_layer_deactivate_indication)
        else $error("lost framing handled wrongly");
    a_idle_ones_count: assert property (
        state == NTA_STATE_ACTIVE && rx.rx_bit_valid && rx.rx_bit && ones_cnt == IDLE_ONES - 1
        && !deactivate_request |-> ##[1:2] state == NTA_STATE_PENDING_ACTIVATION)
        else $error("idle run not declared");
    a_tx_per_state: assert property (
        tx_signal == (state == NTA_STATE_ACTIVE ? NTA_TX_OPERATIONAL_FRAMES :
        state == NTA_STATE_PENDING_ACTIVATION ? NTA_TX_FRAMED_ACTIVATION_SIGNAL : NTA_TX_IDLE_LINE_SIGNAL))
        else $error("line signal does not match state");
    a_act_req_pending: assert property (
        (state == NTA_STATE_DEACTIVATED || state == NTA_STATE_PENDING_DEACTIVATION) && activate_request
        && !deactivate_request |=> state == NTA_STATE_PENDING_ACTIVATION)
        else $error("activate request ignored");
    a_deact_req_guard: assert property (
        (state == NTA_STATE_ACTIVE || state == NTA_STATE_PENDING_ACTIVATION) && deactivate_request
        |=> state == NTA_STATE_PENDING_DEACTIVATION && ind.link_layer_deactivate_indication)
        else $error("deactivate request mishandled");
    a_guard_expiry: assert property (
        state == NTA_STATE_PENDING_DEACTIVATION && $past(state) != NTA_STATE_PENDING_DEACTIVATION
        |-> ##[GUARD_LO:GUARD_HI] state != NTA_STATE_PENDING_DEACTIVATION)
        else $error("guard timer did not expire in time");
    a_ind_one_cycle: assert property (
        $rose(ind.link_layer_activate_indication) |=> !ind.link_layer_activate_indication)
        else $error("activate indication longer than one cycle");
endmodule

bind nta_activation_fsm nta_activation_fsm_monitor #(.GUARD_MS(GUARD_MS), .MS_CYCLES(MS_CYCLES),
    .IDLE_ONES(IDLE_ONES)) u_monitor (.clk(clk), .resetn(resetn), .rx(rx), .activate_request(activate_request),
    .deactivate_request(deactivate_request), .tx_signal(tx_signal), .state(state), .ind(ind));

// File: testbench/nta_activation_fsm_tb.sv
/*
 * self-checking bench for the activation state machine.
 * assumes shortened millisecond tick and the terminal model on the line.
 */
`timescale 1ns/100ps
module nta_activation_fsm_tb;
    import nta_pkg::*;
    localparam int MS_C = 4;
    localparam int GUARD = 2;
    localparam int SUP = 5;
    logic clk, resetn, activate_request, deactivate_request, wake_cmd, sync_en, lost_cmd, ones_cmd;
    nta_rx_s rx;
    nta_tx_e tx_signal;
    nta_state_e state;
    nta_ind_s ind;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;
    nta_activation_fsm #(.SUPERVISION_MS(SUP), .GUARD_MS(GUARD), .HOLD_MS(1), .MS_CYCLES(MS_C), .IDLE_ONES(48),
        .HOLD_ENABLE(1'b0), .FORWARD_MGMT(1'b1)) dut (.clk(clk), .resetn(resetn), .rx(rx),
        .activate_request(activate_request), .deactivate_request(deactivate_request), .tx_signal(tx_signal),
        .state(state), .ind(ind));
    nta_terminal_model u_term (.clk(clk), .resetn(resetn), .tx_signal(tx_signal), .wake_cmd(wake_cmd),
        .sync_en(sync_en), .lost_cmd(lost_cmd), .ones_cmd(ones_cmd), .rx(rx));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_range(input string name, input int lo, input int hi, input int got);
        chk(name, 5'h01, {4'h0, got >= lo && got <= hi});
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_state(input nta_state_e want, input int limit);
        n = 0;
        while (state !== want && n < limit) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (state !== want) begin
            n_mismatch++;
            $display("BAD wait state expected %h seen %h", want, state);
            end_of_test();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_wake_sync;
        @(posedge clk) wake_cmd <= 1'b1;
        @(posedge clk) wake_cmd <= 1'b0;
        #1 chk("state", NTA_STATE_PENDING_ACTIVATION, state);
        chk("tx", NTA_TX_FRAMED_ACTIVATION_SIGNAL, tx_signal);
        @(posedge clk) sync_en <= 1'b1;
        @(posedge clk) sync_en <= 1'b0;
        #1 chk("state", NTA_STATE_ACTIVE, state);
        chk("tx", NTA_TX_OPERATIONAL_FRAMES, tx_signal);
        chk("ind", 5'h14, ind);
        @(posedge clk) #1 chk("ind", 5'h00, ind);
        $display("test wake_sync done");
    endtask
    task automatic t_lost;
        @(posedge clk) lost_cmd <= 1'b1;
        @(posedge clk) lost_cmd <= 1'b0;
        #1 chk("state", NTA_STATE_PENDING_ACTIVATION, state);
        chk("tx", NTA_TX_FRAMED_ACTIVATION_SIGNAL, tx_signal);
        chk("ind", 5'h03, ind);
        @(posedge clk) sync_en <= 1'b1;
        @(posedge clk) sync_en <= 1'b0;
        #1 chk("state", NTA_STATE_ACTIVE, state);
        $display("test lost done");
    endtask
    task automatic t_idle_run;
        @(posedge clk) ones_cmd <= 1'b1;
        repeat (46) @(posedge clk);
        #1 chk("state", NTA_STATE_ACTIVE, state);
        wait_state(NTA_STATE_PENDING_ACTIVATION, 4);
        chk_range("idle edges", 1, 3, n);
        chk("ind", 5'h03, ind);
        chk("tx", NTA_TX_FRAMED_ACTIVATION_SIGNAL, tx_signal);
        @(posedge clk) ones_cmd <= 1'b0;
        sync_en <= 1'b1;
        @(posedge clk) sync_en <= 1'b0;
        #1 chk("state", NTA_STATE_ACTIVE, state);
        $display("test idle_run done");
    endtask
    task automatic t_deact_guard;
        @(posedge clk) deactivate_request <= 1'b1;
        @(posedge clk) deactivate_request <= 1'b0;
        #1 chk("state", NTA_STATE_PENDING_DEACTIVATION, state);
        chk("tx", NTA_TX_IDLE_LINE_SIGNAL, tx_signal);
        chk("ind", 5'h08, ind);
        wait_state(NTA_STATE_DEACTIVATED, 30);
        chk_range("guard edges", GUARD * MS_C - 1, (GUARD + 1) * MS_C + 1, n);
        $display("test deact_guard done");
    endtask
    task automatic t_supervision;
        @(posedge clk) activate_request <= 1'b1;
        @(posedge clk) activate_request <= 1'b0;
        #1 chk("state", NTA_STATE_PENDING_ACTIVATION, state);
        wait_state(NTA_STATE_PENDING_DEACTIVATION, 60);
        chk_range("supervision edges", SUP * MS_C - 2, (SUP + 1) * MS_C + 1, n);
        chk("ind", 5'h08, ind);
        wait_state(NTA_STATE_DEACTIVATED, 30);
        $display("test supervision done");
    endtask
    // ----------------------------------------
    // clock, reset, sequence and watchdog
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        $display("BAD watchdog expected done seen hang");
        end_of_test();
    end
    initial begin
        {resetn, activate_request, deactivate_request, wake_cmd, sync_en, lost_cmd, ones_cmd} = 7'h00;
        repeat (20) @(posedge clk);
        #1 chk("reset", 5'h00, {state, tx_signal, ind[0]} | {1'b0, ind[4:1]});
        @(posedge clk) resetn <= 1'b1;
        @(posedge clk) deactivate_request <= 1'b1;
        @(posedge clk) deactivate_request <= 1'b0;
        #1 chk("state", NTA_STATE_DEACTIVATED, state);
        $display("test reset done");
        t_wake_sync();
        t_lost();
        t_idle_run();
        t_deact_guard();
        t_supervision();
        end_of_test();
    end
endmodule

// File: testbench/nta_terminal_model.sv
/*
 * terminal-side model facing the activation state machine.
 * assumes bench commands change just after a rising clock edge.
 */
`timescale 1ns/100ps
module nta_terminal_model (
    input wire logic clk,
    input wire logic resetn,
    input wire nta_pkg::nta_tx_e tx_signal,
    input wire logic wake_cmd,
    input wire logic sync_en,
    input wire logic lost_cmd,
    input wire logic ones_cmd,
    output nta_pkg::nta_rx_s rx
);
    import nta_pkg::*;
    logic toggle;
    // alternating data breaks any ones run while framing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            toggle <= 1'b0;
        end else begin
            toggle <= !toggle;
        end
    end
    // idle answered by idle at once, frames only in answer to activation
    assign rx.rx_bit = (ones_cmd || tx_signal == NTA_TX_IDLE_LINE_SIGNAL) ? 1'b1 : toggle;
    assign rx.rx_bit_valid = resetn;
    assign rx.synchronized_terminal_frames = sync_en && tx_signal == NTA_TX_FRAMED_ACTIVATION_SIGNAL;
    assign rx.terminal_wake_signal = wake_cmd;
    assign rx.lost_framing = lost_cmd;
endmodule
